/* core/gcp_command_port.sv */
`timescale 1ns/1ps
module gcp_command_port
	import gcp_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic sclIn, // bus clock level
	input wire logic sdaIn, // bus data level
	output logic sclOut, // bus clock drive value, always low
	output logic sclOe, // high while stretching the clock
	output logic sdaOut, // bus data drive value, always low
	output logic sdaOe, // high while pulling data low
	input wire logic hibernate, // core requests hibernate
	input wire logic holdReq, // core asks to stretch (flash or wake)
	input wire logic [7:0] rdData, // byte at memAddr
	input wire logic roLoc, // location at memAddr is read-only
	output logic [7:0] memAddr, // address pointer
	output logic [7:0] wrData, // byte to write
	output logic wrStrobe, // one-cycle write strobe
	output logic asleep, // engine in low-power sleep
	output logic wake // one-cycle wake on own address while hibernate is high
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_RECV = 3'b010,
		S_SEND = 3'b011,
		S_ACKO = 3'b100,
		S_ACKI = 3'b101,
		S_SKIP = 3'b110,
		S_SLEEP = 3'b111
	} gcp_state_e;

	gcp_pins_if ev();
	gcp_pin_front u_front (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.ev(ev)
	);

	////////////////////////////////////////////////////////////////////
	gcp_state_e state, next_state;
	logic [7:0] shift, next_shift;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] ptr, next_ptr;
	logic readMode, next_readMode;
	logic cmdDone, next_cmdDone;
	logic ackLow, next_ackLow;
	logic wrPend, next_wrPend;
	logic [7:0] wrByte, next_wrByte;
	logic wakeP, next_wakeP;
	logic [CNT_W-1:0] lowCnt, next_lowCnt;
	logic released, next_released;

	function automatic logic byteIsOurs(input logic [7:0] b);
		return b[7:1] == TARGET_ADDR;
	endfunction : byteIsOurs

	always_comb begin
		next_state = state;
		next_shift = shift;
		next_bitCnt = bitCnt;
		next_ptr = ptr;
		next_readMode = readMode;
		next_cmdDone = cmdDone;
		next_ackLow = ackLow;
		next_wrPend = 1'b0;
		next_wrByte = wrByte;
		next_wakeP = 1'b0;
		next_released = released;
		if (ev.sclLevel && ev.sdaLevel) begin
			next_lowCnt = '0;
			next_released = 1'b0;
		end else if (lowCnt != CNT_W'(STUCK_CYCLES)) begin
			next_lowCnt = lowCnt + 1'b1;
		end else begin
			next_lowCnt = lowCnt;
			next_released = 1'b1;
		end
		if (released && lowCnt == CNT_W'(STUCK_CYCLES) && !(ev.sclLevel && ev.sdaLevel)) begin
			next_ackLow = 1'b0;
			next_state = S_SLEEP;
		end else if (ev.startSeen && !released) begin
			next_state = S_ADDR;
			next_bitCnt = '0;
			next_ackLow = 1'b0;
			next_cmdDone = 1'b0;
		end else if (ev.stopSeen) begin
			next_state = (hibernate || state == S_SLEEP) ? state : S_IDLE;
			if (state == S_SLEEP && ev.sclLevel && ev.sdaLevel) begin
				next_state = S_IDLE;
			end
			next_ackLow = 1'b0;
		end else begin
			case (state)
				S_IDLE, S_SLEEP: begin
				end
				S_ADDR, S_RECV: begin
					if (ev.sclRise && bitCnt < 4'd8) begin
						next_shift = {shift[6:0], ev.sdaLevel};
						next_bitCnt = bitCnt + 4'd1;
					end else if (ev.sclFall && bitCnt == 4'd8) begin
						next_bitCnt = '0;
						next_state = S_ACKO;
						next_ackLow = 1'b1;
						if (state == S_ADDR) begin
							if (!byteIsOurs(shift)) begin
								next_ackLow = 1'b0;
								next_state = S_SKIP;
							end else begin
								next_wakeP = hibernate;
								next_readMode = shift[0];
							end
						end else if (!cmdDone) begin
							if (shift > MAX_CMD) begin
								next_ackLow = 1'b0;
							end else begin
								next_ptr = shift;
								next_cmdDone = 1'b1;
							end
						end else if (roLoc) begin
							next_ackLow = 1'b0;
						end else begin
							next_wrPend = 1'b1;
							next_wrByte = shift;
							next_ptr = ptr + 8'd1;
						end
					end
				end
				S_ACKO: begin
					if (ev.sclFall) begin
						next_ackLow = 1'b0;
						if (!ackLow) begin
							next_state = S_SKIP;
						end else if (readMode) begin
							next_shift = rdData;
							next_state = S_SEND;
							next_ackLow = ~rdData[7];
							next_bitCnt = 4'd1;
						end else begin
							next_state = S_RECV;
						end
					end
				end
				S_SEND: begin
					if (ev.sclFall) begin
						if (bitCnt == 4'd8) begin
							next_ackLow = 1'b0;
							next_state = S_ACKI;
						end else begin
							next_ackLow = ~shift[3'd7 - bitCnt[2:0]];
							next_bitCnt = bitCnt + 4'd1;
						end
					end
				end
				S_ACKI: begin
					if (ev.sclRise) begin
						if (!ev.sdaLevel) begin
							next_ptr = ptr + 8'd1;
							next_state = S_ACKO;
							next_ackLow = 1'b1;
						end else begin
							next_state = S_SKIP;
						end
					end
				end
				S_SKIP: begin
				end
				default: next_state = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			shift <= 8'h00;
			bitCnt <= 4'h0;
			ptr <= PTR_RESET;
			readMode <= 1'b0;
			cmdDone <= 1'b0;
			ackLow <= 1'b0;
			wrPend <= 1'b0;
			wrByte <= 8'h00;
			wakeP <= 1'b0;
			lowCnt <= '0;
			released <= 1'b0;
		end else begin
			state <= next_state;
			shift <= next_shift;
			bitCnt <= next_bitCnt;
			ptr <= next_ptr;
			readMode <= next_readMode;
			cmdDone <= next_cmdDone;
			ackLow <= next_ackLow;
			wrPend <= next_wrPend;
			wrByte <= next_wrByte;
			wakeP <= next_wakeP;
			lowCnt <= next_lowCnt;
			released <= next_released;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ACKO on a read: the first data bit is counted on leaving (bitCnt loads 1); that
	// bit is driven at the falling edge leaving ACKO, giving a full low phase.
	// write strobe carries the location before the pointer step
	assign memAddr = wrPend ? ptr - 8'd1 : ptr;
	assign wrData = wrByte;
	assign wrStrobe = wrPend;
	assign wake = wakeP;
	assign asleep = state == S_SLEEP;
	assign sdaOut = 1'b0;
	assign sclOut = 1'b0;
	// lines freed once the timer expires
	assign sdaOe = ackLow && !released;
	// stretch for flash or wake, ended by the stuck timer
	// no stretch in SKIP once the address byte names another target; that address byte itself can be stretched
	assign sclOe = holdReq && !ev.sclLevel && state != S_IDLE && state != S_SLEEP
		&& state != S_SKIP && !released;

	////////////////////////////////////////////////////////////////////
	property p_cmd_limit;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_RECV && !cmdDone && ev.sclFall && bitCnt == 4'd8 && shift > MAX_CMD)
		|=> !ackLow && ptr == $past(ptr);
	endproperty
	a_cmd_limit: assert property (p_cmd_limit) else $error("command above limit acked");
	property p_ro_nack;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_RECV && cmdDone && roLoc && ev.sclFall && bitCnt == 4'd8)
		|=> !ackLow && !wrStrobe;
	endproperty
	a_ro_nack: assert property (p_ro_nack) else $error("read-only write acked");
	property p_host_ack_step;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_ACKI && ev.sclRise && !ev.sdaLevel && !released && !ev.startSeen
			&& !ev.stopSeen) |=> ptr == $past(ptr) + 8'd1;
	endproperty
	a_host_ack_step: assert property (p_host_ack_step) else $error("no step on host ack");
	property p_write_step;
		@(posedge sys_clk) disable iff (!rst_n)
		wrStrobe |-> memAddr == $past(ptr) && wrData == $past(shift) ##1 !wrStrobe;
	endproperty
	a_write_step: assert property (p_write_step) else $error("write not consecutive");
	property p_foreign_addr;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_ADDR && ev.sclFall && bitCnt == 4'd8 && !byteIsOurs(shift)
			&& !released && !ev.startSeen && !ev.stopSeen) |=> state == S_SKIP && !wake;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address taken");
	property p_cmd_load;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_RECV && !cmdDone && ev.sclFall && bitCnt == 4'd8 && shift <= MAX_CMD
			&& !released && !ev.startSeen && !ev.stopSeen) |=> ptr == $past(shift);
	endproperty
	a_cmd_load: assert property (p_cmd_load) else $error("pointer not loaded");
	property p_release;
		@(posedge sys_clk) disable iff (!rst_n)
		released |-> !sdaOe && !sclOe;
	endproperty
	a_release: assert property (p_release) else $error("line held after time-out");
	property p_sleep;
		@(posedge sys_clk) disable iff (!rst_n)
		(released && lowCnt == CNT_W'(STUCK_CYCLES) && !(ev.sclLevel && ev.sdaLevel))
			|=> asleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep after stuck bus");
	property p_quick_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_ACKO && readMode && ackLow && ev.sclFall && !released && !ev.startSeen
			&& !ev.stopSeen) |=> shift == $past(rdData);
	endproperty
	a_quick_read: assert property (p_quick_read) else $error("wrong read byte");
	c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wrStrobe);
	c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) state == S_ACKI);
	c_sleep: cover property (@(posedge sys_clk) disable iff (!rst_n) asleep);
	c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) wake);
endmodule : gcp_command_port

/* core/gcp_pin_front.sv */
`timescale 1ns/1ps
module gcp_pin_front (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic sclIn, // bus clock level
	input wire logic sdaIn, // bus data level
	gcp_pins_if.front ev // conditioned events
);
	logic sclQ;
	logic sdaQ;
	logic next_sclQ;
	logic next_sdaQ;
	always_comb begin
		next_sclQ = sclIn;
		next_sdaQ = sdaIn;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= next_sclQ;
			sdaQ <= next_sdaQ;
		end
	end
	// inputs are synchronous, so one stage suffices for edge detection
	assign ev.sclRise = sclIn & ~sclQ;
	assign ev.sclFall = ~sclIn & sclQ;
	assign ev.startSeen = sclIn & sclQ & sdaQ & ~sdaIn;
	assign ev.stopSeen = sclIn & sclQ & ~sdaQ & sdaIn;
	assign ev.sdaLevel = sdaIn;
	assign ev.sclLevel = sclIn;
endmodule : gcp_pin_front

/* core/gcp_pins_if.sv */
`timescale 1ns/1ps
// conditioned bus events passed from the pin front end to the engine
interface gcp_pins_if;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic sdaLevel;
	logic sclLevel;
	modport front (output sclRise, sclFall, startSeen, stopSeen, sdaLevel, sclLevel);
	modport engine (input sclRise, sclFall, startSeen, stopSeen, sdaLevel, sclLevel);
endinterface : gcp_pins_if

/* core/gcp_pkg.sv */
package gcp_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h55;
	localparam logic [7:0] MAX_CMD = 8'h6B;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam int CLK_HZ = 40_000_000;
	localparam int STUCK_MS = 2000;
	localparam int STUCK_CYCLES = (CLK_HZ / 1000) * STUCK_MS;
	localparam int STRETCH_MAX_MS = 80;
	localparam int STRETCH_MAX_CYCLES = (CLK_HZ / 1000) * STRETCH_MAX_MS;
	localparam int WAKE_MAX_MS = 4;
	localparam int WAKE_MAX_CYCLES = (CLK_HZ / 1000) * WAKE_MAX_MS;
	localparam int CNT_W = 27;
endpackage : gcp_pkg

/* verification/gauge_i2c_command_port_test.sv */
`timescale 1ns/1ps
module gauge_i2c_command_port_test;
	import gcp_pkg::*;
	localparam logic [7:0] WR_HDR = {TARGET_ADDR, 1'b0};
	localparam logic [7:0] RD_HDR = {TARGET_ADDR, 1'b1};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hibernate = 1'b0;
	logic holdReq = 1'b0;
	logic sclOut, sclOe, sdaOut, sdaOe, asleep, wake, wrStrobe, roLoc;
	logic hostSclLow, hostSdaLow, a, scl, sda;
	logic [7:0] memAddr, wrData, rdData, d;
	logic [7:0] mem [256];
	int stallCount;
	int wakeCount = 0;
	int bad_count = 0;
	int samples_checked = 0;
	// released lines float up through the pull-ups
	assign scl = ~hostSclLow & (sclOe ? sclOut : 1'b1);
	assign sda = ~hostSdaLow & (sdaOe ? sdaOut : 1'b1);
	assign rdData = mem[memAddr];
	assign roLoc = memAddr < 8'h08;
	always #12.5 sys_clk = ~sys_clk;
	gcp_command_port gcp_command_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(scl),
		.sdaIn(sda), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.hibernate(hibernate), .holdReq(holdReq), .rdData(rdData), .roLoc(roLoc),
		.memAddr(memAddr), .wrData(wrData), .wrStrobe(wrStrobe), .asleep(asleep), .wake(wake));
	gcp_host_model gcp_host_model_i (.sys_clk(sys_clk), .scl(scl), .sda(sda),
		.sclLow(hostSclLow), .sdaLow(hostSdaLow), .stallCount(stallCount));
	always @(posedge sys_clk) begin
		if (wrStrobe === 1'b1)
			mem[memAddr] <= wrData;
		if (wake === 1'b1)
			wakeCount <= wakeCount + 1;
	end
	////////////////////////////////////////
	function automatic logic [7:0] seed(input int i);
		return i[7:0] ^ 8'hA5;
	endfunction : seed
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic put(input logic [7:0] b, input logic ackExp, input string what);
		gcp_host_model_i.xfer(b, 1'b0, d, a);
		check(what, {7'd0, ackExp}, {7'd0, a});
	endtask : put
	task automatic get(input logic hostAck, input logic [7:0] exp, input string what);
		gcp_host_model_i.xfer(8'hFF, hostAck, d, a);
		check(what, exp, d);
	endtask : get
	task automatic bus_start();
		gcp_host_model_i.send_start();
	endtask : bus_start
	task automatic bus_stop();
		gcp_host_model_i.send_stop();
	endtask : bus_stop
	////////////////////////////////////////
	task automatic t_quick_read();
		bus_start();
		put(RD_HDR, 1'b1, "read header");
		get(1'b1, seed(0), "first quick read");
		get(1'b0, seed(1), "second quick read");
		bus_stop();
		bus_start();
		put(RD_HDR, 1'b1, "read header");
		get(1'b0, seed(1), "pointer after nack");
		bus_stop();
	endtask : t_quick_read
	task automatic t_write_read();
		bus_start();
		put(WR_HDR, 1'b1, "write header");
		put(8'h20, 1'b1, "command 0x20");
		put(8'h3C, 1'b1, "data byte 0");
		put(8'hC3, 1'b1, "data byte 1");
		bus_stop();
		check("mem 0x20", 8'h3C, mem[8'h20]);
		check("mem 0x21", 8'hC3, mem[8'h21]);
		bus_start();
		put(WR_HDR, 1'b1, "write header");
		put(8'h20, 1'b1, "command 0x20");
		bus_start();
		put(RD_HDR, 1'b1, "repeated read header");
		get(1'b1, 8'h3C, "read 0x20");
		get(1'b0, 8'hC3, "read 0x21");
		bus_stop();
	endtask : t_write_read
	task automatic t_refuse();
		bus_start();
		put(WR_HDR, 1'b1, "write header");
		put(8'h6C, 1'b0, "command 0x6C");
		bus_stop();
		bus_start();
		put(WR_HDR, 1'b1, "write header");
		put(8'h6B, 1'b1, "command 0x6B");
		bus_stop();
		bus_start();
		put(WR_HDR, 1'b1, "write header");
		put(8'h04, 1'b1, "command 0x04");
		put(8'h77, 1'b0, "read-only data");
		bus_stop();
		check("mem 0x04", seed(4), mem[8'h04]);
	endtask : t_refuse
	task automatic t_address();
		int w0;
		w0 = wakeCount;
		hibernate = 1'b1;
		bus_start();
		put(8'hA8, 1'b0, "foreign header");
		bus_stop();
		check("wakes after foreign", 8'd0, 8'(wakeCount - w0));
		bus_start();
		put(WR_HDR, 1'b1, "own header in hibernate");
		bus_stop();
		hibernate = 1'b0;
		check("wakes after own", 8'd1, 8'(wakeCount - w0));
	endtask : t_address
	task automatic t_stretch();
		holdReq = 1'b1;
		fork
			begin
				bus_start();
				put(WR_HDR, 1'b1, "header after stretch");
				put(8'h30, 1'b1, "command 0x30");
				put(8'h5A, 1'b1, "data byte");
				bus_stop();
			end
			begin
				repeat (200) @(negedge sys_clk);
				check("clock held", 8'd1, {7'd0, sclOe & ~scl});
				holdReq = 1'b0;
			end
		join
		check("mem 0x30", 8'h5A, mem[8'h30]);
	endtask : t_stretch
	////////////////////////////////////////
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = seed(i);
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_quick_read();
		t_write_read();
		t_refuse();
		t_address();
		t_stretch();
		check("host stalls", 8'd0, 8'(stallCount));
		check("engine awake", 8'd0, {7'd0, asleep});
		final_report();
	end
	// hang guard
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		final_report();
	end
endmodule : gauge_i2c_command_port_test

/* verification/gcp_host_model.sv */
`timescale 1ns/1ps
// host controller; lines are open drain, so it only ever pulls low
module gcp_host_model (
	input wire logic sys_clk, // system clock
	input wire logic scl, // resolved bus clock
	input wire logic sda, // resolved bus data
	output logic sclLow, // host pulls clock low
	output logic sdaLow, // host pulls data low
	output int stallCount // clock releases that never rose
);
	localparam int QTR = 5;
	// 66 us of bus free time, in 25 ns cycles
	localparam int GAP = 2640;
	// no checksum, voltage or polling commands sent
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
		stallCount = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	////////////////////////////////////////
	// tolerate held clock
	task automatic rel_scl();
		int w;
		w = 0;
		sclLow = 1'b0;
		tick(1);
		while (scl !== 1'b1 && w < 20000) begin
			tick(1);
			w++;
		end
		if (w >= 20000)
			stallCount++;
		tick(QTR);
	endtask : rel_scl
	task automatic send_start();
		sdaLow = 1'b0;
		tick(QTR);
		rel_scl();
		sdaLow = 1'b1;
		tick(QTR);
		sclLow = 1'b1;
		tick(QTR);
	endtask : send_start
	task automatic send_stop();
		sdaLow = 1'b1;
		tick(QTR);
		rel_scl();
		sdaLow = 1'b0;
		tick(QTR);
		tick(GAP);
	endtask : send_stop
	// nine clocks, msb first; the ninth carries the acknowledge
	task automatic xfer(input logic [7:0] dout, input logic ackOut, output logic [7:0] din,
		output logic ackIn);
		logic [8:0] v;
		logic [8:0] r;
		v = {dout, ~ackOut};
		r = '0;
		for (int i = 8; i >= 0; i--) begin
			sdaLow = ~v[i];
			tick(QTR);
			rel_scl();
			r = {r[7:0], sda};
			sclLow = 1'b1;
			tick(QTR);
		end
		sdaLow = 1'b0;
		tick(1);
		din = r[8:1];
		ackIn = ~r[0];
	endtask : xfer
endmodule : gcp_host_model
